// ==== design/phyan_regs.svh ====
/*
 Register indices, field positions, reset values and identity fields of the
 management register bank. Assumes a Wishbone byte address of four times the index.
*/
`ifndef PHYAN_REGS_SVH
`define PHYAN_REGS_SVH

// Register indices (byte address = 4 * index)
`define PHYAN_IDX_CTRL      3'h0
`define PHYAN_IDX_STAT      3'h1
`define PHYAN_IDX_ID_HIGH   3'h2
`define PHYAN_IDX_ID_LOW    3'h3
`define PHYAN_IDX_ADV       3'h4
`define PHYAN_IDX_PARTNER   3'h5

// Control and status bits
`define PHYAN_CTRL_AN_EN    12
`define PHYAN_CTRL_RESTART  9
`define PHYAN_STAT_COMPLETE 5
`define PHYAN_STAT_ABILITY  3

// Code word bits
`define PHYAN_CW_NEXT_PAGE  15
`define PHYAN_CW_ACK        14
`define PHYAN_CW_RFAULT     13
`define PHYAN_CW_PAUSE      10

// Identity values, arbitrary
`define PHYAN_OUI           22'h0b5c3d
`define PHYAN_MODEL         6'h2b
`define PHYAN_REVISION      4'h3

// Reset values
`define PHYAN_ADV_RESET     16'h01e1
`define PHYAN_PAUSE_RESET   1'b1
`define PHYAN_CTRL_RESET    16'h1000

// Writable advertisement bits: 13, 9:5, 4:0
`define PHYAN_ADV_WMASK     16'h23ff

`endif

// ==== design/phyan_pkg.sv ====
/*
 Types for the management register bank.
 Assumes phyan_regs.svh supplies the numeric constants.
*/
`default_nettype none

package phyan_pkg;
   typedef enum logic [3:0] {
      PHYAN_IDLE    = 4'h1,
      PHYAN_ABILITY = 4'h2,
      PHYAN_ACKWAIT = 4'h4,
      PHYAN_DONE    = 4'h8
   } phyan_state_e;
endpackage : phyan_pkg

`default_nettype wire

// ==== design/phyan_regbank.sv ====
/*
 Management registers of a PHY: identity pair, advertisement, partner ability,
 plus control and status, over a classic Wishbone slave; a small negotiation
 tracker counts matching partner code words. Assumes received code words arrive
 as one-cycle strobes from logic on clk_i.
// What this block does
// - 32-bit identity split over registers two, three
// - Only low 22 identifier bits stored
// - Identifier 21:6 high register, 5:0 at 15:10
// - Model number in bits 9:4
// - Revision number identifies silicon revision
// - Next page unsupported, never offered
// - Acknowledge set after three identical words
// - Remote fault writable, resets zero
// - Pause read-only variant reset; 12:11 reserved
// - Ability bits 9:5 writable, reset 01111
// - Selector writable, resets to 802.3
// - Partner word held; valid when complete
// - Partner register ignores writes
// - Partner fields mirror received word, reset zero
// - Partner bit 14 reports partner acknowledge
// - Complete flag sticky, set when finished
// - Restart bit self-clears after restarting
*/
// The Wishbone slave port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "phyan_regs.svh"

module phyan_regbank (
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // Wishbone slave
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        we_i,
   input  wire logic [7:0]  adr_i,
   input  wire logic [3:0]  sel_i,
   input  wire logic [31:0] dat_i,
   output logic      [31:0] dat_o,
   output logic             ack_o,
   // Negotiation link side
   input  wire logic        rx_valid_i,
   input  wire logic [15:0] rx_word_i,
   output logic      [15:0] tx_word_o,
   output logic             an_restart_o,
   output logic             an_complete_o
);

   logic [15:0]  ctrl_reg, ctrl_next;
   logic [15:0]  adv_reg, adv_next;
   logic [15:0]  partner_reg, partner_next;
   logic [15:0]  last_reg, last_next;
   logic [1:0]   match_reg, match_next;
   logic         complete_reg, complete_next;
   logic         ack_reg, ack_next;
   logic [31:0]  dat_reg, dat_next;
   logic         restart_reg, restart_next;
   phyan_pkg::phyan_state_e state_reg, state_next;

   // Literals cannot be part-selected, so identity and reset go through these
   localparam logic [21:0] OUI_BITS       = `PHYAN_OUI;
   localparam logic [15:0] ADV_RESET_BITS = `PHYAN_ADV_RESET;

   logic         req, wr_do, same;
   logic         done_hit;
   logic [15:0]  wmask, rd_word;
   logic [2:0]   idx;

   function automatic logic mapped(input logic [7:0] a);
      mapped = (a[7:5] == 3'h0) && (a[4:2] <= `PHYAN_IDX_PARTNER) && (a[1:0] == 2'h0);
   endfunction : mapped

   function automatic logic [15:0] lane_mask(input logic [3:0] s);
      lane_mask = {{8{s[1]}}, {8{s[0]}}};
   endfunction : lane_mask

   assign idx   = adr_i[4:2];
   assign req   = cyc_i && stb_i;
   // Write lands on the edge where the master samples ack
   assign wr_do = req && we_i && ack_reg && mapped(adr_i);
   assign wmask = lane_mask(sel_i);
   // Acknowledge bit does not take part in the match
   assign same  = (rx_word_i & 16'hbfff) == (last_reg & 16'hbfff);
   // Partner acknowledge while waiting for it finishes negotiation
   assign done_hit = (state_reg == phyan_pkg::PHYAN_ACKWAIT) && rx_valid_i && rx_word_i[`PHYAN_CW_ACK];

   // Read mux; identity is built from constants so writes cannot reach it
   always_comb begin
      rd_word = 16'h0000;
      case (idx)
         `PHYAN_IDX_CTRL:    rd_word = ctrl_reg;
         `PHYAN_IDX_STAT:    rd_word = {10'h000, complete_reg, 1'b0, 1'b1, 3'h0};
         `PHYAN_IDX_ID_HIGH: rd_word = OUI_BITS[21:6];
         `PHYAN_IDX_ID_LOW:  rd_word = {OUI_BITS[5:0], `PHYAN_MODEL, `PHYAN_REVISION};
         `PHYAN_IDX_ADV:     rd_word = adv_reg;
         `PHYAN_IDX_PARTNER: rd_word = partner_reg;
         default:            rd_word = 16'h0000;
      endcase
   end

   // Bus handshake: one wait state, ack for one cycle
   always_comb begin
      ack_next = req && !ack_reg;
      dat_next = dat_reg;
      if (req && !ack_reg) begin
         dat_next = (!we_i && mapped(adr_i)) ? {16'h0000, rd_word} : 32'h0000_0000;
      end
   end

   // Register writes and negotiation tracking
   always_comb begin
      ctrl_next     = ctrl_reg;
      adv_next      = adv_reg;
      partner_next  = partner_reg;
      last_next     = last_reg;
      match_next    = match_reg;
      complete_next = complete_reg;
      restart_next  = 1'b0;
      state_next    = state_reg;
      ctrl_next[`PHYAN_CTRL_RESTART] = 1'b0;
      if (wr_do && idx == `PHYAN_IDX_CTRL) begin
         ctrl_next = (ctrl_reg & ~wmask) | (dat_i[15:0] & wmask & 16'h1200);
         restart_next = wmask[`PHYAN_CTRL_RESTART] && dat_i[`PHYAN_CTRL_RESTART];
      end
      if (wr_do && idx == `PHYAN_IDX_ADV) begin
         // Next page, acknowledge, pause and reserved bits are outside the mask
         adv_next = (adv_reg & ~(wmask & `PHYAN_ADV_WMASK)) | (dat_i[15:0] & wmask & `PHYAN_ADV_WMASK);
      end
      // Partner register has no write path at all
      case (state_reg)
         phyan_pkg::PHYAN_IDLE: begin
            if (ctrl_reg[`PHYAN_CTRL_AN_EN]) begin
               state_next = phyan_pkg::PHYAN_ABILITY;
            end
         end
         phyan_pkg::PHYAN_ABILITY: begin
            if (rx_valid_i) begin
               last_next = rx_word_i;
               if (same && match_reg == 2'h2) begin
                  // Third identical word in a row
                  adv_next[`PHYAN_CW_ACK] = 1'b1;
                  partner_next = rx_word_i;
                  state_next = phyan_pkg::PHYAN_ACKWAIT;
               end else if (same) begin
                  match_next = match_reg + 2'h1;
               end else begin
                  match_next = 2'h1;
               end
            end
         end
         phyan_pkg::PHYAN_ACKWAIT: begin
            if (rx_valid_i && rx_word_i[`PHYAN_CW_ACK]) begin
               partner_next = rx_word_i;
               complete_next = 1'b1;
               state_next = phyan_pkg::PHYAN_DONE;
            end
         end
         phyan_pkg::PHYAN_DONE: begin
            state_next = phyan_pkg::PHYAN_DONE;
         end
         default: begin
            state_next = phyan_pkg::PHYAN_IDLE;
         end
      endcase
      // Restart drops progress; a completion landing in the same cycle still sets the flag
      if (restart_reg || !ctrl_reg[`PHYAN_CTRL_AN_EN]) begin
         adv_next[`PHYAN_CW_ACK] = 1'b0;
         match_next = 2'h0;
         last_next = 16'h0000;
         if (restart_reg && !done_hit) begin
            complete_next = 1'b0;
         end
         state_next = phyan_pkg::PHYAN_IDLE;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_reg     <= `PHYAN_CTRL_RESET;
         adv_reg      <= `PHYAN_ADV_RESET | ({15'h0000, `PHYAN_PAUSE_RESET} << `PHYAN_CW_PAUSE);
         partner_reg  <= 16'h0000;
         last_reg     <= 16'h0000;
         match_reg    <= 2'h0;
         complete_reg <= 1'b0;
         ack_reg      <= 1'b0;
         dat_reg      <= 32'h0000_0000;
         restart_reg  <= 1'b0;
         state_reg    <= phyan_pkg::PHYAN_IDLE;
      end else begin
         ctrl_reg     <= ctrl_next;
         adv_reg      <= adv_next;
         partner_reg  <= partner_next;
         last_reg     <= last_next;
         match_reg    <= match_next;
         complete_reg <= complete_next;
         ack_reg      <= ack_next;
         dat_reg      <= dat_next;
         restart_reg  <= restart_next;
         state_reg    <= state_next;
      end
   end

   assign ack_o         = ack_reg;
   assign dat_o         = dat_reg;
   assign tx_word_o     = adv_reg;
   assign an_restart_o  = restart_reg;
   assign an_complete_o = complete_reg;

   ack_single_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ack_o |=> !ack_o)
      else $error("ack held longer than one cycle");

   id_high_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (ack_o && !we_i && adr_i == 8'h08) |-> dat_o == {16'h0000, OUI_BITS[21:6]})
      else $error("identity high word wrong");

   id_low_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (ack_o && !we_i && adr_i == 8'h0c) |-> dat_o[15:0] == {OUI_BITS[5:0], `PHYAN_MODEL, `PHYAN_REVISION})
      else $error("identity low word wrong");

   no_next_page_a: assert property (@(posedge clk_i) disable iff (rst_i)
      !tx_word_o[`PHYAN_CW_NEXT_PAGE])
      else $error("next page offered");

   ack_three_a: assert property (@(posedge clk_i) disable iff (rst_i)
      $rose(adv_reg[`PHYAN_CW_ACK]) |-> $past(rx_valid_i) && $past(same) && $past(match_reg) == 2'h2)
      else $error("acknowledge set without three matches");

   rfault_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (ack_o && we_i && cyc_i && stb_i && adr_i == 8'h10 && sel_i[1])
      |=> adv_reg[`PHYAN_CW_RFAULT] == $past(dat_i[`PHYAN_CW_RFAULT]))
      else $error("remote fault write lost");

   adv_reset_a: assert property (@(posedge clk_i)
      $fell(rst_i) |-> adv_reg[9:0] == ADV_RESET_BITS[9:0])
      else $error("advertisement reset value wrong");

   partner_ro_a: assert property (@(posedge clk_i) disable iff (rst_i)
      !rx_valid_i |=> $stable(partner_reg))
      else $error("partner register changed without a code word");

   complete_sticky_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (complete_reg && !restart_reg) |=> complete_reg)
      else $error("complete flag dropped");

   restart_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (an_restart_o && !done_hit) |=> !an_restart_o && !ctrl_reg[`PHYAN_CTRL_RESTART] ##1 !complete_reg)
      else $error("restart bit did not clear");

   id_upper_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (ack_o && !we_i && (adr_i == 8'h08 || adr_i == 8'h0c)) |-> dat_o[31:16] == 16'h0000)
      else $error("identity read has upper bits set");

   model_field_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (ack_o && !we_i && adr_i == 8'h0c) |-> dat_o[9:4] == `PHYAN_MODEL)
      else $error("model number field wrong");

   revision_field_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (ack_o && !we_i && adr_i == 8'h0c) |-> dat_o[3:0] == `PHYAN_REVISION)
      else $error("revision field wrong");

   ack_bit_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
      $fell(adv_reg[`PHYAN_CW_ACK]) |-> $past(restart_reg) || !$past(ctrl_reg[`PHYAN_CTRL_AN_EN]))
      else $error("acknowledge bit dropped without restart or disable");

   rfault_reset_a: assert property (@(posedge clk_i)
      $fell(rst_i) |-> !adv_reg[`PHYAN_CW_RFAULT])
      else $error("remote fault not zero after reset");

   pause_fixed_a: assert property (@(posedge clk_i) disable iff (rst_i)
      adv_reg[`PHYAN_CW_PAUSE] == `PHYAN_PAUSE_RESET && adv_reg[12:11] == 2'h0)
      else $error("pause or reserved advertisement bits changed");

   ability_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (ack_o && we_i && cyc_i && stb_i && adr_i == 8'h10 && sel_i[1] && sel_i[0])
      |=> adv_reg[9:5] == $past(dat_i[9:5]))
      else $error("ability bits write lost");

   selector_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (ack_o && we_i && cyc_i && stb_i && adr_i == 8'h10 && sel_i[0])
      |=> adv_reg[4:0] == $past(dat_i[4:0]))
      else $error("selector write lost");

   partner_capture_a: assert property (@(posedge clk_i) disable iff (rst_i)
      $changed(partner_reg) |-> $past(rx_valid_i) && partner_reg == $past(rx_word_i))
      else $error("partner register differs from received word");

   partner_reset_a: assert property (@(posedge clk_i)
      $fell(rst_i) |-> partner_reg == 16'h0000)
      else $error("partner register not zero after reset");

   partner_ack_a: assert property (@(posedge clk_i) disable iff (rst_i)
      $rose(complete_reg) |-> partner_reg[`PHYAN_CW_ACK])
      else $error("completion without partner acknowledge");

   complete_cause_a: assert property (@(posedge clk_i) disable iff (rst_i)
      $rose(complete_reg) |-> $past(state_reg) == phyan_pkg::PHYAN_ACKWAIT && $past(rx_valid_i)
      && $past(rx_word_i[`PHYAN_CW_ACK]))
      else $error("complete set without acknowledged word");

   complete_status_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (ack_o && !we_i && adr_i == 8'h04) |-> dat_o[`PHYAN_STAT_COMPLETE] == $past(complete_reg))
      else $error("status complete bit wrong");

   restart_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
      $rose(ctrl_reg[`PHYAN_CTRL_RESTART]) |-> an_restart_o)
      else $error("restart write gave no restart pulse");

endmodule : phyan_regbank

`default_nettype wire

// ==== testbench/phyan_link_partner.sv ====
/*
 Behavioural link partner: sends one-cycle received code word strobes.
 Assumes a caller invokes send() from a process synchronised to clk_i.
*/
`timescale 1ns/1ps
`default_nettype none

module phyan_link_partner (
   // Clock
   input  wire logic        clk_i,
   // Code word strobe
   output logic             valid_o,
   output logic      [15:0] word_o
);
   initial begin
      valid_o = 1'b0;
      word_o  = 16'h0000;
   end

   // Word line shows the inverse between strobes, so stale data never looks valid
   task automatic send(input logic [15:0] w);
      @(posedge clk_i);
      valid_o <= 1'b1;
      word_o  <= w;
      @(posedge clk_i);
      valid_o <= 1'b0;
      word_o  <= ~w;
   endtask : send
endmodule : phyan_link_partner

`default_nettype wire

// ==== testbench/testbench.sv ====
/*
 Self-checking bench of the register bank: Wishbone reads and writes, link words.
 Assumes the link partner model drives the received code word port.
*/
`timescale 1ns/1ps
`default_nettype none
`include "phyan_regs.svh"

module testbench;
   localparam logic [21:0] OUI  = `PHYAN_OUI;
   localparam logic [15:0] IDH  = OUI[21:6];
   localparam logic [15:0] IDL  = {OUI[5:0], `PHYAN_MODEL, `PHYAN_REVISION};
   localparam logic [15:0] ADV0 = {5'h00, `PHYAN_PAUSE_RESET, 10'h1e1};
   localparam logic [15:0] LP   = 16'h2561;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        cyc_i = 1'b0;
   logic        stb_i = 1'b0;
   logic        we_i  = 1'b0;
   logic [7:0]  adr_i = 8'h00;
   logic [3:0]  sel_i = 4'h0;
   logic [31:0] dat_i = 32'h0;
   logic [31:0] dat_o;
   logic        ack_o;
   logic        rx_valid;
   logic [15:0] rx_word;
   logic [15:0] tx_word_o;
   logic        an_restart_o;
   logic        an_complete_o;
   logic [31:0] q;
   int          err_total = 0;
   int          n_checks  = 0;
   int          n;

   always #5 clk_i = ~clk_i;

   phyan_regbank i_phyan_regbank (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
      .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
      .rx_valid_i(rx_valid), .rx_word_i(rx_word), .tx_word_o(tx_word_o),
      .an_restart_o(an_restart_o), .an_complete_o(an_complete_o));
   phyan_link_partner i_phyan_link_partner (.clk_i(clk_i), .valid_o(rx_valid), .word_o(rx_word));

   task automatic end_sim();
      if (err_total == 0 && n_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : end_sim

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // Single classic cycle; bounded wait on ack
   task automatic wb(input logic w, input logic [7:0] a, input logic [15:0] d, input logic [3:0] s);
      int k;
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i  <= w;
      adr_i <= a;
      sel_i <= s;
      dat_i <= {16'h0000, d};
      k = 0;
      do begin
         @(posedge clk_i);
         k++;
      end while (ack_o !== 1'b1 && k < 20);
      q = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      if (k >= 20) begin
         chk(32'h1, 32'h0);
         end_sim();
      end
   endtask : wb

   task automatic rd(input logic [7:0] a, input logic [15:0] exp);
      wb(1'b0, a, 16'h0000, 4'h3);
      chk(q, {16'h0000, exp});
   endtask : rd

   initial begin
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      chk({16'h0, tx_word_o}, {16'h0, ADV0});
      rd(8'h08, IDH);
      rd(8'h0c, IDL);
      rd(8'h10, ADV0);
      rd(8'h14, 16'h0000);
      rd(8'h04, 16'h0008);
      rd(8'h1c, 16'h0000);
      wb(1'b1, 8'h08, 16'hffff, 4'h3);
      wb(1'b1, 8'h0c, 16'hffff, 4'h3);
      wb(1'b1, 8'h14, 16'hffff, 4'h3);
      rd(8'h08, IDH);
      rd(8'h0c, IDL);
      rd(8'h14, 16'h0000);
      // Software keeps next page and the unsupported T4 bit clear
      wb(1'b1, 8'h10, 16'h7dff, 4'h3);
      rd(8'h10, 16'h25ff);
      chk({16'h0, tx_word_o}, 32'h25ff);
      wb(1'b1, 8'h10, 16'h0000, 4'h1);
      rd(8'h10, 16'h2500);
      wb(1'b1, 8'h10, 16'h01e1, 4'h3);
      rd(8'h10, ADV0);
      wb(1'b1, 8'h00, 16'h1200, 4'h3);
      for (n = 0; n < 8 && an_restart_o !== 1'b1; n++) @(posedge clk_i);
      chk({31'h0, an_restart_o}, 32'h1);
      rd(8'h00, 16'h1000);
      // Broken run of matches must not acknowledge
      i_phyan_link_partner.send(LP);
      i_phyan_link_partner.send(LP);
      i_phyan_link_partner.send(16'h0021);
      rd(8'h10, ADV0);
      for (n = 0; n < 3; n++) i_phyan_link_partner.send(LP);
      repeat (2) @(posedge clk_i);
      chk({16'h0, tx_word_o}, {16'h0, ADV0 | 16'h4000});
      rd(8'h14, LP);
      chk({31'h0, an_complete_o}, 32'h0);
      i_phyan_link_partner.send(LP | 16'h4000);
      repeat (2) @(posedge clk_i);
      chk({31'h0, an_complete_o}, 32'h1);
      rd(8'h14, LP | 16'h4000);
      wb(1'b0, 8'h04, 16'h0000, 4'h3);
      chk(q, 32'h0000_0028);
      // Words after completion are ignored
      for (n = 0; n < 4; n++) i_phyan_link_partner.send(16'h0001);
      rd(8'h14, LP | 16'h4000);
      chk({31'h0, an_complete_o}, 32'h1);
      // Disabling drops the acknowledge bit but keeps completion
      wb(1'b1, 8'h00, 16'h0000, 4'h3);
      rd(8'h00, 16'h0000);
      rd(8'h10, ADV0);
      chk({31'h0, an_complete_o}, 32'h1);
      end_sim();
   end
endmodule : testbench

`default_nettype wire
